// File: core/ufc_pkg.sv
// Package: constants, types and register map of the UART flow control unit.
package ufc_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int ERR_W = 3;
	localparam int LEVEL_W = 7;

	// Received character with its three error status bits.
	typedef struct packed {
		logic [ERR_W-1:0] err;
		logic [DATA_W-1:0] data;
	} ufc_rx_char_s;

	// Flow character sender progress.
	typedef enum logic [1:0] {
		FS_IDLE,
		FS_SECOND
	} ufc_flow_e;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_IER = 8'h04;
	localparam logic [7:0] OFS_IIR_FCR = 8'h08;
	localparam logic [7:0] OFS_LCR = 8'h0C;
	localparam logic [7:0] OFS_MCR = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_EFR = 8'h18;
	localparam logic [7:0] OFS_TCR = 8'h1C;
	localparam logic [7:0] OFS_TLR = 8'h20;
	localparam logic [7:0] OFS_ON1 = 8'h24;
	localparam logic [7:0] OFS_ON2 = 8'h28;
	localparam logic [7:0] OFS_OFF1 = 8'h2C;
	localparam logic [7:0] OFS_OFF2 = 8'h30;

	// ----------------------------------------
	// Field positions and codes
	// ----------------------------------------
	localparam int EFR_AUTO_CTS = 7;
	localparam int EFR_AUTO_RTS = 6;
	localparam int EFR_SPECIAL = 5;
	localparam int MCR_RTS = 1;
	localparam int MCR_XON_ANY = 5;
	localparam int IER_XOFF = 5;
	localparam int FCR_EN = 0;
	localparam logic [7:0] IIR_NONE = 8'h01;
	localparam logic [7:0] IIR_XOFF = 8'h10;
	localparam logic [7:0] RESET_CTRL = 8'h00;

	// Selectable trigger levels, indexed by the two-bit field.
	localparam logic [LEVEL_W-1:0] RX_TRIG0 = 7'h08;
	localparam logic [LEVEL_W-1:0] RX_TRIG1 = 7'h10;
	localparam logic [LEVEL_W-1:0] RX_TRIG2 = 7'h38;
	localparam logic [LEVEL_W-1:0] RX_TRIG3 = 7'h3C;
	localparam logic [LEVEL_W-1:0] TX_TRIG0 = 7'h08;
	localparam logic [LEVEL_W-1:0] TX_TRIG1 = 7'h10;
	localparam logic [LEVEL_W-1:0] TX_TRIG2 = 7'h20;
	localparam logic [LEVEL_W-1:0] TX_TRIG3 = 7'h38;
	localparam logic [LEVEL_W-1:0] TRIG_ONE = 7'h01;

endpackage : ufc_pkg

// File: core/ufc_fifo.sv
// Flip-flop FIFO with fill level, used for the receive and transmit queues.
`timescale 1ns/1ps
module ufc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 64
) (
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Fill side.
	input wire logic push,
	input wire logic [W-1:0] din,
	// Drain side.
	input wire logic pop,
	output logic [W-1:0] dout,
	// Status.
	output logic [$clog2(DEPTH):0] level,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] level_q;
	logic do_push;
	logic do_pop;

	// Pushes into a full queue and pops from an empty one are ignored.
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign full = (level_q == (AW+1)'(DEPTH));
	assign empty = (level_q == '0);
	assign level = level_q;
	assign dout = mem_q[rd_q];

	// Storage has no reset; only pointers define content.
	always_ff @(posedge clk_sys) begin
		if (ce && do_push) begin
			mem_q[wr_q] <= din;
		end
	end

	// Pointers and level move together so level is always exact.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			level_q <= '0;
		end else if (ce) begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
			level_q <= level_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : ufc_fifo

// File: core/ufc_flow_top.sv
// One UART channel's FIFOs with hardware and software flow control behind APB.
//
// Notes on behaviour
// - Receive and transmit queues hold 64 characters; receive entries keep three error bits.
// - After reset FIFOs are disabled, so both trigger levels are one character.
// - Trigger levels come from fifo_control selections or trigger_level nibbles, per direction.
// - enhanced_feature bit 7 enables automatic CTS, bit 6 automatic RTS.
// - With automatic CTS, a data character starts only while CTS is active; flow characters are not gated.
// - With automatic CTS on, CTS transitions raise no host event.
// - Automatic RTS is active below the halt threshold, dropped when reached.
// - Automatic RTS returns once the level falls to the resume threshold.
// - One more character after RTS drops is still accepted and stored.
// - enhanced_feature bits 3:2 choose which halt and resume characters are sent.
// - enhanced_feature bits 1:0 choose which characters the receiver compares.
// - Receive 11 matches either single character, or needs a pair when transmit is 11/00.
// - modem_control bit 5 lets any character resume a halted transmitter.
// - enhanced_feature bit 5 flags the second halt character without halting; it is stored.
// - Reading interrupt_identification clears the halt character flag.
// - A halt match stops transmission after the current character and flags it if enabled.
// - A resume match clears the flag and lets transmission continue.
// - Halt characters are sent when the receive level passes the halt threshold.
// - Resume characters are sent when the receive level reaches the resume threshold.
// - Flow characters are framed like data and cut to the word length.
// - Without automatic RTS, modem_control bit 1 drives RTS low; RTS is high after reset.
// - A pending halt flag reads as identification code 01 0000.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ufc_flow_top
	import ufc_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
) (
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Characters from the receiver.
	input wire logic rx_char_valid,
	input wire ufc_pkg::ufc_rx_char_s rx_char,
	// Characters to the transmitter.
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// Modem pins and events.
	input wire logic cts_n,
	output logic rts_n,
	output logic cts_change,
	output logic xoff_int,
	// DMA requests.
	output logic rx_dma_request_n,
	output logic tx_dma_request_n
);
	import ufc_pkg::*;

	if (FIFO_DEPTH < 4 || FIFO_DEPTH > 64 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
		$error("FIFO_DEPTH must be a power of two from 4 to 64");
	end

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// A four-bit threshold nibble counts in steps of four characters.
	function automatic logic [LEVEL_W-1:0] nib_level(input logic [3:0] nib);
		return {1'b0, nib, 2'b00};
	endfunction : nib_level

	// Keep only the low bits that the configured word length sends.
	function automatic logic [7:0] word_mask(input logic [7:0] d, input logic [1:0] wl);
		logic [7:0] m;
		m = 8'hFF >> (2'd3 - wl);
		return d & m;
	endfunction : word_mask

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ier_q;
	logic [7:0] fcr_q;
	logic [7:0] lcr_q;
	logic [7:0] mcr_q;
	logic [7:0] efr_q;
	logic [7:0] tcr_q;
	logic [7:0] tlr_q;
	logic [7:0] on1_q;
	logic [7:0] on2_q;
	logic [7:0] off1_q;
	logic [7:0] off2_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic hit_d;
	logic acc;
	logic done_wr;
	logic done_rd;

	// Flow state.
	logic sw_halt_q;
	logic flag_q;
	logic rts_halt_q;
	logic off_sent_q;
	logic pend_q;
	logic pend_off_q;
	logic off_first_q;
	logic on_first_q;
	logic cts_n_q;
	ufc_flow_e fs_q;
	logic out_full_q;
	logic out_free;
	logic out_flow_q;
	logic [7:0] out_data_q;

	// Queue wires.
	ufc_rx_char_s rxq_dout;
	logic [LEVEL_W-1:0] rx_level;
	logic [LEVEL_W-1:0] tx_level;
	logic rx_full;
	logic rx_empty;
	logic tx_full;
	logic tx_empty;
	logic [7:0] txq_dout;
	logic rx_push;
	logic rx_pop;
	logic tx_push;
	logic tx_pop;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------

	// One wait state: read data is captured in the first access cycle, writes take effect as the transfer ends in the next.
	assign acc = psel && penable;
	assign done_wr = acc && pready_q && pwrite;
	assign done_rd = acc && pready_q && !pwrite;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// Read multiplexer; unmapped addresses read zero and answer with an error.
	always_comb begin
		rd_d = '0;
		hit_d = 1'b1;
		case (paddr)
			OFS_DATA: rd_d = 32'(rxq_dout);
			OFS_IER: rd_d = 32'(ier_q);
			OFS_IIR_FCR: rd_d = 32'((flag_q && ier_q[IER_XOFF]) ? IIR_XOFF : IIR_NONE);
			OFS_LCR: rd_d = 32'(lcr_q);
			OFS_MCR: rd_d = 32'(mcr_q);
			OFS_STATUS: rd_d = {13'h0000, off_sent_q, rts_halt_q, sw_halt_q, 1'b0, tx_level,
				1'b0, rx_level};
			OFS_EFR: rd_d = 32'(efr_q);
			OFS_TCR: rd_d = 32'(tcr_q);
			OFS_TLR: rd_d = 32'(tlr_q);
			OFS_ON1: rd_d = 32'(on1_q);
			OFS_ON2: rd_d = 32'(on2_q);
			OFS_OFF1: rd_d = 32'(off1_q);
			OFS_OFF2: rd_d = 32'(off2_q);
			default: hit_d = 1'b0;
		endcase
	end

	// Handshake and answer registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			pready_q <= acc && !pready_q;
			if (acc && !pready_q) begin
				pslverr_q <= !hit_d;
				prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
			end
		end
	end

	// Control registers; all cleared by reset so both FIFOs start disabled.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ier_q <= RESET_CTRL;
			fcr_q <= RESET_CTRL;
			lcr_q <= RESET_CTRL;
			mcr_q <= RESET_CTRL;
			efr_q <= RESET_CTRL;
			tcr_q <= RESET_CTRL;
			tlr_q <= RESET_CTRL;
		end else if (ce && done_wr) begin
			case (paddr)
				OFS_IER: ier_q <= pwdata[7:0];
				OFS_IIR_FCR: fcr_q <= pwdata[7:0];
				OFS_LCR: lcr_q <= pwdata[7:0];
				OFS_MCR: mcr_q <= pwdata[7:0];
				OFS_EFR: efr_q <= pwdata[7:0];
				OFS_TCR: tcr_q <= pwdata[7:0];
				OFS_TLR: tlr_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Flow characters keep their values through reset, as software loads them once.
	always_ff @(posedge clk_sys) begin
		if (ce && done_wr) begin
			case (paddr)
				OFS_ON1: on1_q <= pwdata[7:0];
				OFS_ON2: on2_q <= pwdata[7:0];
				OFS_OFF1: off1_q <= pwdata[7:0];
				OFS_OFF2: off2_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Queues
	// ----------------------------------------
	assign tx_push = done_wr && (paddr == OFS_DATA);
	assign rx_pop = done_rd && (paddr == OFS_DATA);

	// Receive queue carries the error bits beside each character.
	ufc_fifo #(.W(DATA_W + ERR_W), .DEPTH(FIFO_DEPTH)) u_rxq (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.push(rx_push),
		.din(rx_char),
		.pop(rx_pop),
		.dout(rxq_dout),
		.level(rx_level),
		.full(rx_full),
		.empty(rx_empty)
	);

	// Transmit queue.
	ufc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.push(tx_push),
		.din(pwdata[7:0]),
		.pop(tx_pop),
		.dout(txq_dout),
		.level(tx_level),
		.full(tx_full),
		.empty(tx_empty)
	);

	// ----------------------------------------
	// Trigger levels and DMA requests
	// ----------------------------------------
	logic [LEVEL_W-1:0] rx_trig;
	logic [LEVEL_W-1:0] tx_trig;
	logic [LEVEL_W-1:0] tx_space;

	// A nonzero trigger_level nibble overrides the fifo_control selection.
	always_comb begin
		rx_trig = TRIG_ONE;
		tx_trig = TRIG_ONE;
		if (fcr_q[FCR_EN]) begin
			case (fcr_q[7:6])
				2'd0: rx_trig = RX_TRIG0;
				2'd1: rx_trig = RX_TRIG1;
				2'd2: rx_trig = RX_TRIG2;
				default: rx_trig = RX_TRIG3;
			endcase
			case (fcr_q[5:4])
				2'd0: tx_trig = TX_TRIG0;
				2'd1: tx_trig = TX_TRIG1;
				2'd2: tx_trig = TX_TRIG2;
				default: tx_trig = TX_TRIG3;
			endcase
			if (tlr_q[7:4] != 4'h0) begin
				rx_trig = nib_level(tlr_q[7:4]);
			end
			if (tlr_q[3:0] != 4'h0) begin
				tx_trig = nib_level(tlr_q[3:0]);
			end
		end
	end

	assign tx_space = LEVEL_W'(FIFO_DEPTH) - tx_level;
	assign rx_dma_request_n = !(rx_level >= rx_trig);
	assign tx_dma_request_n = !(tx_space >= tx_trig);

	// ----------------------------------------
	// Hardware flow control
	// ----------------------------------------
	logic auto_cts;
	logic auto_rts;
	logic [LEVEL_W-1:0] halt_lvl;
	logic [LEVEL_W-1:0] resume_lvl;

	assign auto_cts = efr_q[EFR_AUTO_CTS];
	assign auto_rts = efr_q[EFR_AUTO_RTS];
	assign halt_lvl = nib_level(tcr_q[3:0]);
	assign resume_lvl = nib_level(tcr_q[7:4]);

	// Hysteresis between the halt and resume levels avoids RTS chatter.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rts_halt_q <= 1'b0;
		end else if (ce) begin
			if (rx_level >= halt_lvl) begin
				rts_halt_q <= 1'b1;
			end else if (rx_level <= resume_lvl) begin
				rts_halt_q <= 1'b0;
			end
		end
	end

	// Reset clears modem_control, so RTS starts high.
	assign rts_n = auto_rts ? rts_halt_q : !mcr_q[MCR_RTS];

	// CTS edges are reported only when the transmitter is not gated by them.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cts_n_q <= 1'b1;
			cts_change <= 1'b0;
		end else if (ce) begin
			cts_n_q <= cts_n;
			cts_change <= (cts_n != cts_n_q) && !auto_cts;
		end
	end

	// ----------------------------------------
	// Software flow control, receive side
	// ----------------------------------------
	logic [1:0] rxm;
	logic [1:0] txm;
	logic seq;
	logic is_off1;
	logic is_off2;
	logic is_on1;
	logic is_on2;
	logic special;
	logic off_hit;
	logic on_hit;
	logic any_hit;
	logic consume;
	logic iir_read;

	assign rxm = efr_q[1:0];
	assign txm = efr_q[3:2];
	assign seq = (rxm == 2'b11) && (txm == 2'b11 || txm == 2'b00);
	assign is_off1 = rx_char.data == off1_q;
	assign is_off2 = rx_char.data == off2_q;
	assign is_on1 = rx_char.data == on1_q;
	assign is_on2 = rx_char.data == on2_q;
	assign special = rx_char_valid && efr_q[EFR_SPECIAL] && is_off2;

	// Receive compare selection, single or paired.
	always_comb begin
		off_hit = 1'b0;
		on_hit = 1'b0;
		case (rxm)
			2'b10: begin
				off_hit = is_off1;
				on_hit = is_on1;
			end
			2'b01: begin
				off_hit = is_off2;
				on_hit = is_on2;
			end
			2'b11: begin
				off_hit = seq ? (off_first_q && is_off2) : (is_off1 || is_off2);
				on_hit = seq ? (on_first_q && is_on2) : (is_on1 || is_on2);
			end
			default: ;
		endcase
		off_hit = off_hit && rx_char_valid && !special;
		on_hit = on_hit && rx_char_valid;
	end

	// Any other character resumes a halted transmitter when enabled.
	assign any_hit = rx_char_valid && sw_halt_q && mcr_q[MCR_XON_ANY] && !off_hit && !on_hit;
	// Flow characters are swallowed; the special character and data are stored.
	assign consume = (rxm != 2'b00) && !special
		&& (is_off1 || is_off2 || is_on1 || is_on2);
	// Storing continues while there is room, so the one late character still fits.
	assign rx_push = rx_char_valid && !consume;
	assign iir_read = done_rd && (paddr == OFS_IIR_FCR);

	// Halt, resume and pair tracking.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sw_halt_q <= 1'b0;
			off_first_q <= 1'b0;
			on_first_q <= 1'b0;
		end else if (ce) begin
			if (rx_char_valid) begin
				off_first_q <= is_off1;
				on_first_q <= is_on1;
			end
			if (off_hit) begin
				sw_halt_q <= 1'b1;
			end else if (on_hit || any_hit) begin
				sw_halt_q <= 1'b0;
			end
		end
	end

	// Halt character flag: a new match wins over a clear in the same cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (ce) begin
			if ((off_hit || special) && ier_q[IER_XOFF]) begin
				flag_q <= 1'b1;
			end else if (iir_read || on_hit || any_hit) begin
				flag_q <= 1'b0;
			end
		end
	end

	assign xoff_int = flag_q && ier_q[IER_XOFF];

	// ----------------------------------------
	// Software flow control, transmit side
	// ----------------------------------------

	// Queue a halt request past the halt level and a resume request at the resume level.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			off_sent_q <= 1'b0;
			pend_q <= 1'b0;
			pend_off_q <= 1'b0;
		end else if (ce) begin
			if (txm == 2'b00) begin
				off_sent_q <= 1'b0;
				pend_q <= 1'b0;
			end else if (!off_sent_q && rx_level > halt_lvl) begin
				off_sent_q <= 1'b1;
				pend_q <= 1'b1;
				pend_off_q <= 1'b1;
			end else if (off_sent_q && rx_level <= resume_lvl) begin
				off_sent_q <= 1'b0;
				pend_q <= 1'b1;
				pend_off_q <= 1'b0;
			end else if (fs_q == FS_IDLE && out_free && pend_q) begin
				pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Transmit output stage
	// ----------------------------------------
	logic data_ok;
	logic [7:0] first_char;
	logic [7:0] second_char;

	assign out_free = !out_full_q || (tx_valid && tx_ready);
	assign data_ok = !sw_halt_q && !(auto_cts && cts_n);
	// A held data character waits here, re-checking CTS before it starts.
	assign tx_valid = out_full_q && (out_flow_q || data_ok);
	assign tx_data = out_data_q;
	assign tx_pop = out_free && fs_q == FS_IDLE && !pend_q && !tx_empty && data_ok;
	assign first_char = pend_off_q ? (txm[1] ? off1_q : off2_q) : (txm[1] ? on1_q : on2_q);
	assign second_char = pend_off_q ? off2_q : on2_q;

	// Flow characters jump ahead of queued data; pairs go out first then second.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fs_q <= FS_IDLE;
			out_full_q <= 1'b0;
			out_flow_q <= 1'b0;
			out_data_q <= 8'h00;
		end else if (ce && out_free) begin
			out_full_q <= 1'b1;
			out_flow_q <= 1'b1;
			case (fs_q)
				FS_SECOND: begin
					out_data_q <= word_mask(second_char, lcr_q[1:0]);
					fs_q <= FS_IDLE;
				end
				default: begin
					if (pend_q) begin
						out_data_q <= word_mask(first_char, lcr_q[1:0]);
						fs_q <= (txm == 2'b11) ? FS_SECOND : FS_IDLE;
					end else if (tx_pop) begin
						out_data_q <= word_mask(txq_dout, lcr_q[1:0]);
						out_flow_q <= 1'b0;
					end else begin
						out_full_q <= 1'b0;
						out_flow_q <= 1'b0;
					end
				end
			endcase
		end
	end

endmodule : ufc_flow_top

// File: test/ufc_flow_sva.sv
// Assertions on the ports of the flow control unit.
`timescale 1ns/1ps
module ufc_flow_sva
	import ufc_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Streams, pins and requests.
	input wire logic rx_char_valid,
	input wire ufc_pkg::ufc_rx_char_s rx_char,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic cts_n,
	input wire logic rts_n,
	input wire logic cts_change,
	input wire logic xoff_int,
	input wire logic rx_dma_request_n,
	input wire logic tx_dma_request_n
);
	logic [7:0] efr_q;
	logic [7:0] mcr_q;
	logic [7:0] tcr_q;
	logic [7:0] lvl_q;
	logic lvl_ok_q;
	logic done;
	logic rd_iir;
	assign done = psel && penable && pready;
	assign rd_iir = done && !pwrite && paddr == OFS_IIR_FCR;
	// Shadow copies of the EFR, MCR and TCR control registers, taken from completed writes.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			efr_q <= 8'h00;
			mcr_q <= 8'h00;
			tcr_q <= 8'h00;
		end else if (done && pwrite) begin
			if (paddr == OFS_EFR) efr_q <= pwdata[7:0];
			if (paddr == OFS_MCR) mcr_q <= pwdata[7:0];
			if (paddr == OFS_TCR) tcr_q <= pwdata[7:0];
		end
	end
	// Receive level; trusted only until flow characters could be swallowed.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lvl_q <= 8'h00;
			lvl_ok_q <= 1'b1;
		end else begin
			lvl_q <= lvl_q + 8'(rx_char_valid && lvl_q < FIFO_DEPTH)
				- 8'(done && !pwrite && paddr == OFS_DATA && lvl_q != 0);
			if (efr_q[1:0] != 2'b00) lvl_ok_q <= 1'b0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("APB answer missing");
	a_cts_gate: assert property (efr_q[7] && efr_q[3:0] == 4'h0 && cts_n |-> !tx_valid)
		else $error("send while CTS inactive");
	a_cts_quiet: assert property (efr_q[7] && $past(efr_q[7]) |-> !cts_change)
		else $error("CTS event with auto CTS");
	a_cts_event: assert property (!efr_q[7] && $changed(cts_n) |-> ##[1:2] cts_change)
		else $error("CTS event missing");
	a_rts_manual: assert property (!efr_q[6] |-> rts_n == !mcr_q[MCR_RTS])
		else $error("RTS not from modem control");
	a_rts_halt: assert property (lvl_ok_q && efr_q[6]
		&& lvl_q >= {2'b00, tcr_q[3:0], 2'b00} |-> ##[0:1] rts_n) else $error("RTS not halted");
	a_rts_resume: assert property (lvl_ok_q && efr_q[6]
		&& lvl_q <= {2'b00, tcr_q[7:4], 2'b00} |-> ##[0:1] !rts_n) else $error("RTS not resumed");
	a_iir_code: assert property (rd_iir |-> prdata[7:0] == (xoff_int ? IIR_XOFF : IIR_NONE))
		else $error("wrong identification code");
	a_iir_clear: assert property (rd_iir && !rx_char_valid |=> !xoff_int)
		else $error("halt flag not cleared");
endmodule : ufc_flow_sva

// File: test/ufc_remote_model.sv
// Remote UART model: sends received characters and takes transmitted ones.
`timescale 1ns/1ps
module ufc_remote_model (
	// Clock, reset and bench controls.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cts_block,
	input wire logic slow,
	// Device side.
	input wire logic rts_n,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic cts_n,
	output logic rx_char_valid,
	output logic [10:0] rx_char
);
	logic [7:0] got_q[$];
	logic [2:0] cnt_q;
	initial begin
		rx_char_valid = 1'b0;
		rx_char = 11'h2AA;
	end
	// Take characters; a slow remote stalls on a fixed beat.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'h0;
			tx_ready <= 1'b0;
			cts_n <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			tx_ready <= !slow || cnt_q[1];
			cts_n <= cts_block;
			if (tx_valid && tx_ready) got_q.push_back(tx_data);
		end
	end
	// Send one character; a late one was already started when RTS fell.
	task automatic send_char(input logic [10:0] c, input bit late);
		int n;
		n = 0;
		while (!late && rts_n !== 1'b0 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
		rx_char_valid <= 1'b1;
		rx_char <= c;
		@(posedge clk_sys);
		rx_char_valid <= 1'b0;
		rx_char <= ~c;
	endtask : send_char
endmodule : ufc_remote_model

// File: test/ufc_flow_top_test.sv
// Self-checking bench for the flow control unit.
`timescale 1ns/1ps
module ufc_flow_top_test;
	import ufc_pkg::*;
	logic clk_sys, rst, psel, penable, pwrite, cts_block, slow, pready, pslverr, err_seen;
	logic rx_char_valid, tx_valid, tx_ready, cts_n, rts_n, cts_change, xoff_int;
	logic rx_dma_request_n, tx_dma_request_n;
	logic [7:0] paddr, tx_data;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] rx_char, c;
	logic [10:0] exp_a[9];
	int num_errors, num_checks, seed, i;
	ufc_flow_top #(.FIFO_DEPTH(64)) uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .cts_n(cts_n),
		.rts_n(rts_n), .cts_change(cts_change), .xoff_int(xoff_int),
		.rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n));
	ufc_remote_model mdl (.clk_sys(clk_sys), .rst(rst), .cts_block(cts_block), .slow(slow),
		.rts_n(rts_n), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.cts_n(cts_n), .rx_char_valid(rx_char_valid), .rx_char(rx_char));
	// Compare one value and count it.
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask : check
	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("pready", 1, pready);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Wait, bounded, until the remote has taken n characters.
	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (mdl.got_q.size() < n && k < 300) begin
			@(posedge clk_sys);
			k++;
		end
		check("tx count", n, mdl.got_q.size());
	endtask : wait_got
	task automatic complete_run;
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	// 50 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Watchdog: a hang counts as a mismatch.
	initial begin
		repeat (20000) @(posedge clk_sys);
		check("finished", 1, 0);
		complete_run;
	end
	// Main sequence: reset state, hardware flow, then software flow after a second reset.
	initial begin
		seed = 71;
		rst = 1'b1;
		{psel, penable, pwrite, slow} = 4'h0;
		cts_block = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check("rts_n", 1, rts_n);
		check("rx dma", 1, rx_dma_request_n);
		check("tx dma", 0, tx_dma_request_n);
		apb(0, OFS_IIR_FCR, 0);
		check("iir", IIR_NONE, rd[7:0]);
		apb(0, 8'h3C, 0);
		check("slverr", 1, err_seen);
		apb(1, OFS_MCR, 32'h2);
		@(posedge clk_sys);
		check("rts_n on", 0, rts_n);
		cts_block <= 1'b0;
		apb(1, OFS_MCR, 0);
		apb(1, OFS_TCR, 32'h12);
		apb(1, OFS_EFR, 32'h40);
		for (i = 0; i < 9; i++) begin
			exp_a[i] = 11'($random(seed));
			if (i == 8) begin
				repeat (2) @(posedge clk_sys);
				check("rts_n halt", 1, rts_n);
			end
			mdl.send_char(exp_a[i], i == 8);
		end
		repeat (2) @(posedge clk_sys);
		apb(0, OFS_STATUS, 0);
		check("rx level", 9, rd[6:0]);
		for (i = 0; i < 9; i++) begin
			apb(0, OFS_DATA, 0);
			check("rx char", exp_a[i], rd[10:0]);
			repeat (2) @(posedge clk_sys);
			if (i == 3 || i == 4) check("rts_n resume", i == 3, rts_n);
		end
		cts_block <= 1'b1;
		repeat (3) @(posedge clk_sys);
		apb(1, OFS_EFR, 32'h80);
		apb(1, OFS_LCR, 3);
		apb(1, OFS_DATA, 32'hA5);
		repeat (10) @(posedge clk_sys);
		check("tx held", 0, mdl.got_q.size());
		cts_block <= 1'b0;
		wait_got(1);
		check("tx char", 8'hA5, mdl.got_q[0]);
		slow <= 1'b1;
		for (i = 0; i < 4; i++) begin
			apb(1, OFS_LCR, i);
			apb(1, OFS_DATA, 32'hFF);
			wait_got(i + 2);
			check("masked", 8'hFF >> (3 - i), mdl.got_q[i + 1]);
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		mdl.got_q.delete();
		for (i = 0; i < 4; i++) apb(1, 8'(OFS_ON1 + 4 * i), 32'h11 + i);
		apb(1, OFS_LCR, 3);
		apb(1, OFS_IER, 32'h20);
		apb(1, OFS_TCR, 32'h12);
		apb(1, OFS_EFR, 32'h0A);
		mdl.send_char(11'h013, 1);
		repeat (3) @(posedge clk_sys);
		check("xoff_int", 1, xoff_int);
		apb(1, OFS_DATA, 32'h5A);
		repeat (10) @(posedge clk_sys);
		check("tx halted", 0, mdl.got_q.size());
		apb(0, OFS_IIR_FCR, 0);
		check("iir halt", IIR_XOFF, rd[7:0]);
		@(posedge clk_sys);
		check("xoff_int clear", 0, xoff_int);
		mdl.send_char(11'h011, 1);
		wait_got(1);
		check("resumed", 8'h5A, mdl.got_q[0]);
		for (i = 0; i < 9; i++) begin
			c = {4'h1, 7'($random(seed))};
			mdl.send_char(c, 1);
		end
		wait_got(2);
		check("halt sent", 8'h13, mdl.got_q[1]);
		for (i = 0; i < 5; i++) apb(0, OFS_DATA, 0);
		wait_got(3);
		check("resume sent", 8'h11, mdl.got_q[2]);
		complete_run;
	end
endmodule : ufc_flow_top_test
bind ufc_flow_top ufc_flow_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva (.clk_sys(clk_sys), .rst(rst),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
	.rx_char(rx_char), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.cts_n(cts_n), .rts_n(rts_n), .cts_change(cts_change), .xoff_int(xoff_int),
	.rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n));
